// ### logic/mask_invert_pkg.sv
// Shared constants, command codes and carrier types of the mask/invert data path.
package mask_invert_pkg;

   // ----------------------------------------------------------------
   // Register map and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MODE_REG_THREE = 8'h00;
   localparam logic [7:0] OFS_MODE_REG_THIRTEEN = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam int BIT_RD_INVERT = 6;
   localparam int BIT_WR_INVERT = 7;
   localparam int BIT_MASK_OFF = 5;
   localparam int BIT_ILLEGAL = 0;
   localparam int BIT_BUSY = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_RD_INVERT = 1'b0;
   localparam logic RST_WR_INVERT = 1'b0;
   localparam logic RST_MASK_OFF = 1'b0;

   // ----------------------------------------------------------------
   // Data path figures
   // ----------------------------------------------------------------
   localparam int LANES = 2;
   localparam int LANE_BITS = 8;
   localparam int BURST_BEATS = 16;
   localparam int READ_INVERT_ABOVE = 4;
   localparam int MASK_ONES_MIN = 5;

   // Column spacing the controller keeps, in clock cycles.
   localparam int CCD_BL16_CYCLES = 8;
   localparam int CCD_BL32_CYCLES = 16;
   localparam int MASKED_WRITE_SPACING_CYCLES = 32;
   localparam int BL32_EXTRA_CYCLES = 8;

   // ----------------------------------------------------------------
   // Commands and states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_WRITE = 3'h0,
      CMD_MASKED_WRITE = 3'h1,
      CMD_MODE_REG_WRITE = 3'h2,
      CMD_READ = 3'h3,
      CMD_MODE_REG_READ = 3'h4,
      CMD_WRITE_FIFO = 3'h5,
      CMD_READ_FIFO = 3'h6,
      CMD_READ_CAL = 3'h7
   } cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WRITE = 3'h2,
      ST_READ = 3'h4
   } phase_type;

   // Link pins as sampled together through the synchroniser.
   typedef struct packed {
      logic strobe;
      logic cmd_valid;
      cmd_type cmd;
      logic [15:0] dq;
      logic [1:0] mi;
   } link_pins_type;

endpackage : mask_invert_pkg

// ### logic/lane_write_decode.sv
// Per-lane decode of received write data and the mask/invert pin.
`timescale 1ns/1ps
module lane_write_decode
   import mask_invert_pkg::*;
(
   // Received beat
   input wire logic [7:0] data_i,
   input wire logic mi_i,
   // Mode
   input wire logic masked_i,
   input wire logic wr_invert_i,
   // Result
   output logic [7:0] data_o,
   output logic store_o
);

   // Masked writes with inversion on read the mask from the upper six bits.
   always_comb begin
      data_o = (wr_invert_i && mi_i) ? ~data_i : data_i; // R10
      store_o = 1'b1;
      if (masked_i && !wr_invert_i) begin
         store_o = !mi_i; // R12
      end else if (masked_i) begin
         store_o = !(!mi_i && ($countones(data_i[7:2]) >= MASK_ONES_MIN)); // R13
      end
   end

endmodule : lane_write_decode

// ### logic/lane_read_encode.sv
// Per-lane inversion encode of read data.
`timescale 1ns/1ps
module lane_read_encode
   import mask_invert_pkg::*;
(
   // Array data and mode
   input wire logic [7:0] data_i,
   input wire logic rd_invert_i,
   // Pin values
   output logic [7:0] data_o,
   output logic mi_o
);

   // Inverting heavy bytes keeps the count of driven ones at four or less.
   always_comb begin
      mi_o = rd_invert_i && ($countones(data_i) > READ_INVERT_ABOVE); // R11
      data_o = mi_o ? ~data_i : data_i;
   end

endmodule : lane_read_encode

// ### logic/dram_byte_mask_inversion.sv
// Mask/invert pin handling for the write, read and training data paths.
// Function
// R1 - Masking on writes, inversion on writes and reads, per lane
// R2 - Mode three bit six enables read inversion
// R3 - Mode three bit seven enables write inversion
// R4 - Mode thirteen bit five low enables masking
// R5 - Two double-rate mask/invert pins, data-like
// R6 - Controller avoids masked writes while masking off
// R7 - Masking and write inversion off: pin ignored
// R8 - Controller drives pin low on plain writes
// R9 - Read inversion off: pin drivers off on reads
// R10 - Write inversion: pin high inverts the byte
// R11 - Read bytes above four ones invert, pin high
// R12 - Masked write, no inversion: pin high skips
// R13 - Masked write, inversion: low pin, five ones masks
// R14 - Write training stores pin, no mask or invert
// R15 - Read training returns the stored pattern
// R16 - Controller spaces column commands eight cycles
// R17 - Controller spaces long-burst column commands sixteen
// R18 - Controller spaces same-bank masked writes thirty-two
// R19 - Long writes add eight cycles to spacing
// R20 - Controller delays write after read with termination
// R21 - All functions off: pin undriven in read training
`timescale 1ns/1ps
module dram_byte_mask_inversion
   import mask_invert_pkg::*;
#(
   parameter int BEATS = BURST_BEATS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link from the controller
   input wire logic strobe_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_code_i,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   input wire logic [1:0] mask_invert_pin_i,
   output logic [1:0] mask_invert_pin_o,
   output logic [1:0] mask_invert_pin_oe_o,
   // Array side
   output logic arr_wr_valid_o,
   output logic [15:0] arr_wr_data_o,
   output logic [1:0] arr_wr_lane_o,
   output logic arr_rd_beat_o,
   input wire logic [15:0] arr_rd_data_i
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam int BW = $clog2(BEATS + 1);
   localparam int IW = $clog2(BEATS);
   localparam logic [BW-1:0] LAST_BEAT = BW'(BEATS - 1);
   localparam logic [BW-1:0] END_BEAT = BW'(BEATS);

   typedef struct packed {
      link_pins_type s1;
      link_pins_type s2;
      logic strb_prev;
      phase_type phase;
      cmd_type kind;
      logic [BW-1:0] beat;
      logic rd_inv;
      logic wr_inv;
      logic mask_off;
      logic illegal;
      logic ack;
      logic [31:0] rdat;
      logic [15:0] dq;
      logic dq_oe;
      logic [1:0] mi;
      logic [1:0] mi_oe;
      logic wr_valid;
      logic [15:0] wr_data;
      logic [1:0] wr_lane;
      logic rd_beat;
      logic [BEATS-1:0][17:0] fifo;
   } state_type;

   state_type st_ff;
   state_type nxt_st;
   link_pins_type pins;
   logic edge_w;
   logic rise_w;
   logic any_en;
   logic wr_gate;
   logic [1:0] mi_rx;
   logic [15:0] dec_data;
   logic [1:0] dec_store;
   logic [15:0] enc_data;
   logic [1:0] enc_mi;
   logic [17:0] fifo_word;
   logic req;

   // ----------------------------------------------------------------
   // Link sampling and per-lane data path
   // ----------------------------------------------------------------

   // All link pins share one synchroniser so data lines stay aligned with the strobe.
   assign pins = '{strobe: strobe_i, cmd_valid: cmd_valid_i, cmd: cmd_type'(cmd_code_i),
                   dq: dq_i, mi: mask_invert_pin_i};
   assign edge_w = st_ff.s2.strobe ^ st_ff.strb_prev; // R5
   assign rise_w = edge_w && st_ff.s2.strobe;
   assign any_en = !st_ff.mask_off || st_ff.wr_inv || st_ff.rd_inv;
   assign wr_gate = !st_ff.mask_off || st_ff.wr_inv;
   // Receivers are off when neither masking nor write inversion needs the pin.
   assign mi_rx = wr_gate ? st_ff.s2.mi : 2'h0; // R7
   assign fifo_word = st_ff.fifo[st_ff.beat[IW-1:0]];
   assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;

   // One decoder and one encoder per byte lane.
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : g_lane
         lane_write_decode u_dec (
            .data_i(st_ff.s2.dq[l*LANE_BITS +: LANE_BITS]),
            .mi_i(mi_rx[l]),
            .masked_i(st_ff.kind == CMD_MASKED_WRITE),
            .wr_invert_i(st_ff.wr_inv),
            .data_o(dec_data[l*LANE_BITS +: LANE_BITS]),
            .store_o(dec_store[l])
         ); // R1
         lane_read_encode u_enc (
            .data_i(arr_rd_data_i[l*LANE_BITS +: LANE_BITS]),
            .rd_invert_i(st_ff.rd_inv),
            .data_o(enc_data[l*LANE_BITS +: LANE_BITS]),
            .mi_o(enc_mi[l])
         ); // R1
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Register writes land at the edge where ack rises; reads of holes return zero.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.strb_prev = st_ff.s2.strobe;
      nxt_st.wr_valid = 1'b0;
      nxt_st.rd_beat = 1'b0;
      nxt_st.ack = req;
      if (req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == OFS_MODE_REG_THREE) begin
            nxt_st.rd_inv = wb_dat_i[BIT_RD_INVERT]; // R2
            nxt_st.wr_inv = wb_dat_i[BIT_WR_INVERT]; // R3
         end else if (wb_adr_i == OFS_MODE_REG_THIRTEEN) begin
            nxt_st.mask_off = wb_dat_i[BIT_MASK_OFF]; // R4
         end else if (wb_adr_i == OFS_STATUS && wb_dat_i[BIT_ILLEGAL]) begin
            nxt_st.illegal = 1'b0;
         end
      end
      if (req) begin
         nxt_st.rdat = 32'h0;
         if (wb_adr_i == OFS_MODE_REG_THREE) begin
            nxt_st.rdat[BIT_RD_INVERT] = st_ff.rd_inv;
            nxt_st.rdat[BIT_WR_INVERT] = st_ff.wr_inv;
         end else if (wb_adr_i == OFS_MODE_REG_THIRTEEN) begin
            nxt_st.rdat[BIT_MASK_OFF] = st_ff.mask_off;
         end else if (wb_adr_i == OFS_STATUS) begin
            nxt_st.rdat[BIT_ILLEGAL] = st_ff.illegal;
            nxt_st.rdat[BIT_BUSY] = st_ff.phase != ST_IDLE;
         end
      end
      case (st_ff.phase)
         ST_IDLE: begin
            nxt_st.dq_oe = 1'b0;
            nxt_st.mi_oe = 2'h0;
            if (rise_w && st_ff.s2.cmd_valid) begin
               nxt_st.kind = st_ff.s2.cmd;
               nxt_st.beat = '0;
               // A masked write with masking off is dropped and flagged; set beats clear.
               if (st_ff.s2.cmd == CMD_MASKED_WRITE && st_ff.mask_off) begin
                  nxt_st.illegal = 1'b1; // R6
               end else if (st_ff.s2.cmd inside {CMD_READ, CMD_MODE_REG_READ,
                                                 CMD_READ_FIFO, CMD_READ_CAL}) begin
                  nxt_st.phase = ST_READ;
               end else begin
                  nxt_st.phase = ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            if (edge_w) begin
               nxt_st.beat = st_ff.beat + BW'(1);
               if (st_ff.kind == CMD_WRITE_FIFO) begin
                  // Training keeps the pin as pattern, or zero with all functions off, and never masks or inverts.
                  nxt_st.fifo[st_ff.beat[IW-1:0]] =
                     {(any_en ? st_ff.s2.mi : 2'h0), st_ff.s2.dq}; // R14
               end else begin
                  nxt_st.wr_valid = 1'b1;
                  nxt_st.wr_data = dec_data; // R10
                  nxt_st.wr_lane = dec_store; // R12 R13
               end
               if (st_ff.beat == LAST_BEAT) begin
                  nxt_st.phase = ST_IDLE;
               end
            end
         end
         ST_READ: begin
            if (edge_w && st_ff.beat == END_BEAT) begin
               nxt_st.dq_oe = 1'b0;
               nxt_st.mi_oe = 2'h0;
               nxt_st.phase = ST_IDLE;
            end else if (edge_w) begin
               nxt_st.beat = st_ff.beat + BW'(1);
               nxt_st.dq_oe = 1'b1;
               if (st_ff.kind inside {CMD_READ_FIFO, CMD_READ_CAL}) begin
                  nxt_st.dq = fifo_word[15:0]; // R15
                  nxt_st.mi = fifo_word[17:16];
                  nxt_st.mi_oe = {LANES{any_en}}; // R21
               end else begin
                  nxt_st.dq = enc_data; // R11
                  nxt_st.mi = enc_mi;
                  nxt_st.mi_oe = {LANES{st_ff.rd_inv}}; // R9
                  nxt_st.rd_beat = 1'b1;
               end
            end
         end
         default: begin
            nxt_st.phase = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register and outputs
   // ----------------------------------------------------------------

   // Synchronous reset leaves every output low and the pins undriven.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.phase <= ST_IDLE;
         st_ff.kind <= CMD_WRITE;
         st_ff.rd_inv <= RST_RD_INVERT;
         st_ff.wr_inv <= RST_WR_INVERT;
         st_ff.mask_off <= RST_MASK_OFF;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_o = st_ff.rdat;
   assign wb_ack_o = st_ff.ack;
   assign dq_o = st_ff.dq;
   assign dq_oe_o = st_ff.dq_oe;
   assign mask_invert_pin_o = st_ff.mi;
   assign mask_invert_pin_oe_o = st_ff.mi_oe;
   assign arr_wr_valid_o = st_ff.wr_valid;
   assign arr_wr_data_o = st_ff.wr_data;
   assign arr_wr_lane_o = st_ff.wr_lane;
   assign arr_rd_beat_o = st_ff.rd_beat;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_read_pin_off: assert property ((st_ff.mi_oe[0] && st_ff.rd_beat) |-> $past(st_ff.rd_inv)) // R9
      else $error("Pin driven on a read with read inversion off.");
   a_read_invert_lane: assert property ((st_ff.mi_oe[0] && st_ff.rd_beat) // R11
      |-> st_ff.mi[0] == ($countones($past(arr_rd_data_i[7:0])) > READ_INVERT_ABOVE)
      && st_ff.dq[7:0] == (st_ff.mi[0] ? ~$past(arr_rd_data_i[7:0])
      : $past(arr_rd_data_i[7:0])))
      else $error("Read lane inversion does not match the ones count.");
   a_write_invert: assert property (($past(st_ff.kind) == CMD_WRITE // R10
      && $past(st_ff.wr_inv) && st_ff.wr_valid)
      |-> st_ff.wr_data[7:0] == ($past(st_ff.s2.mi[0])
      ? ~$past(st_ff.s2.dq[7:0]) : $past(st_ff.s2.dq[7:0])))
      else $error("Write byte not inverted per the pin.");
   a_write_pin_ignored: assert property (($past(st_ff.kind) == CMD_WRITE // R7
      && !$past(st_ff.wr_inv) && st_ff.wr_valid)
      |-> st_ff.wr_data == $past(st_ff.s2.dq) && st_ff.wr_lane == 2'h3)
      else $error("Plain write altered by the pin.");
   a_mask_plain: assert property (($past(st_ff.kind) == CMD_MASKED_WRITE // R12
      && !$past(st_ff.wr_inv) && st_ff.wr_valid)
      |-> st_ff.wr_lane[0] == !$past(st_ff.s2.mi[0]))
      else $error("Masked write lane store does not follow the pin.");
   a_mask_inverted: assert property (($past(st_ff.kind) == CMD_MASKED_WRITE // R13
      && $past(st_ff.wr_inv) && !$past(st_ff.s2.mi[1])
      && $countones($past(st_ff.s2.dq[15:10])) >= 5 && st_ff.wr_valid)
      |-> !st_ff.wr_lane[1])
      else $error("Upper lane not masked on a five-ones pattern.");
   a_fifo_return: assert property (($past(st_ff.phase) == ST_READ && $past(edge_w) // R15
      && $past(st_ff.kind) == CMD_READ_FIFO && $past(st_ff.beat) != END_BEAT)
      |-> {st_ff.mi, st_ff.dq} == $past(fifo_word))
      else $error("Read training pattern differs from the stored one.");
   a_train_pin_off: assert property ((st_ff.mi_oe[1] && !st_ff.rd_beat && st_ff.dq_oe) // R21
      |-> $past(any_en))
      else $error("Pin driven in read training with all functions off.");
   a_illegal_flag: assert property ((rise_w && st_ff.phase == ST_IDLE // R6
      && st_ff.s2.cmd_valid && st_ff.s2.cmd == CMD_MASKED_WRITE && st_ff.mask_off)
      |=> st_ff.illegal && st_ff.phase == ST_IDLE)
      else $error("Masked write with masking off was not refused.");

endmodule : dram_byte_mask_inversion

// ### verif/host_ctrl_model.sv
// Behavioural memory controller that frames commands and data beats on the link.
`timescale 1ns/1ps
module host_ctrl_model
   import mask_invert_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Link towards the device
   output logic strobe_o,
   output logic cmd_valid_o,
   output logic [2:0] cmd_code_o,
   output logic [15:0] dq_o,
   output logic [1:0] pin_o,
   // Resolved wires and device enables
   input wire logic [15:0] dq_i,
   input wire logic [1:0] pin_i,
   input wire logic dq_oe_i,
   input wire logic [1:0] pin_oe_i
);
   logic [15:0] tx_dq [BURST_BEATS];
   logic [1:0] tx_pin [BURST_BEATS];
   logic [15:0] rx_dq [BURST_BEATS];
   logic [1:0] rx_pin [BURST_BEATS];
   logic [2:0] rx_oe [BURST_BEATS];

   // The strobe rests low between frames, so the device never sees a stray edge.
   initial begin
      strobe_o = 1'b0;
      cmd_valid_o = 1'b0;
      cmd_code_o = 3'h0;
      dq_o = 16'h0000;
      pin_o = 2'b00;
   end

   // Takes the beat that the latest edge brought out, just before the next edge.
   // The device answers three clocks after a pin edge, so a midway look is too early.
   task automatic grab(input int b);
      rx_dq[b] = dq_i;
      rx_pin[b] = pin_i;
      rx_oe[b] = {dq_oe_i, pin_oe_i};
   endtask : grab

   // One frame: command on a rising edge, sixteen beat edges, one closing edge.
   // Data moves midway between edges, which keeps it clear of the sampling window.
   task automatic run_burst(input logic [2:0] cmd);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= cmd;
      repeat (2) @(posedge clk_i);
      strobe_o <= 1'b1;
      for (int i = 1; i <= BURST_BEATS + 1; i++) begin
         repeat (2) @(posedge clk_i);
         cmd_valid_o <= 1'b0;
         // Released lines show the inverse of the last value, never a held copy.
         dq_o <= (i <= BURST_BEATS) ? tx_dq[i - 1] : ~dq_o;
         pin_o <= (i <= BURST_BEATS) ? tx_pin[i - 1] : ~pin_o;
         repeat (2) @(posedge clk_i);
         if (i > 1) grab(i - 2);
         strobe_o <= ~strobe_o;
      end
      repeat (2) @(posedge clk_i);
      grab(BURST_BEATS - 1);
      // Idle gap before the next column command; only short bursts with termination off go out.
      repeat (8) @(posedge clk_i);
   endtask : run_burst
endmodule : host_ctrl_model

// ### verif/dram_byte_mask_inversion_tb_top.sv
// Self-checking bench for the mask/invert data path against a behavioural controller.
`timescale 1ns/1ps
module dram_byte_mask_inversion_tb_top
   import mask_invert_pkg::*;
;
   logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, strobe, cmd_valid, dq_oe;
   logic arr_wr_valid, arr_rd_beat;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   logic [2:0] cmd_code;
   logic [15:0] host_dq, dev_dq, dq_bus, arr_wr_data, arr_rd_data;
   logic [1:0] host_pin, dev_pin, pin_oe, pin_bus, arr_wr_lane;
   logic [15:0] rd_mem [BURST_BEATS];
   logic [15:0] train_dq [BURST_BEATS];
   logic [1:0] train_pin [BURST_BEATS];
   logic [17:0] wr_q [$];
   int rd_idx, bad_count, n_compared, seed;

   // Wire levels follow whichever party has its enable up.
   assign dq_bus = dq_oe ? dev_dq : host_dq;
   assign pin_bus = (pin_oe & dev_pin) | (~pin_oe & host_pin);
   assign arr_rd_data = rd_mem[rd_idx[3:0]];

   dram_byte_mask_inversion dram_byte_mask_inversion_i (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .strobe_i(strobe), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
      .dq_i(dq_bus), .dq_o(dev_dq), .dq_oe_o(dq_oe), .mask_invert_pin_i(pin_bus),
      .mask_invert_pin_o(dev_pin), .mask_invert_pin_oe_o(pin_oe),
      .arr_wr_valid_o(arr_wr_valid), .arr_wr_data_o(arr_wr_data), .arr_wr_lane_o(arr_wr_lane),
      .arr_rd_beat_o(arr_rd_beat), .arr_rd_data_i(arr_rd_data)
   );

   host_ctrl_model host (
      .clk_i(clk), .strobe_o(strobe), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .dq_o(host_dq), .pin_o(host_pin), .dq_i(dq_bus), .pin_i(pin_bus), .dq_oe_i(dq_oe),
      .pin_oe_i(pin_oe)
   );

   // Array model: steps on each consumed beat and logs every store.
   always @(posedge clk) begin
      if (arr_rd_beat === 1'b1) rd_idx <= rd_idx + 1;
      if (arr_wr_valid === 1'b1) wr_q.push_back({arr_wr_lane, arr_wr_data});
   end

   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------
   // Comparison, bus and expectation helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s: %h not %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // Classic single cycle; entered just after a rising edge, request held until ack.
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'hF;
      wb_adr <= adr;
      wb_wdat <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      check(32'(wb_ack), 32'h00000001, "ack");
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask : wb_cycle

   // Stored flag and lane byte for one write beat; m is {mask off, wr inv, rd inv}.
   function automatic logic [8:0] exp_wr(input logic [2:0] c, input logic [7:0] d,
         input logic p, input logic [2:0] m);
      if (c == 3'h1 && !m[1]) return {~p, d};
      if (c == 3'h1 && !p && $countones(d[7:2]) >= MASK_ONES_MIN) return {1'b0, d};
      return {1'b1, (m[1] && p) ? ~d : d};
   endfunction : exp_wr

   function automatic logic [8:0] exp_rd(input logic [7:0] d, input logic on);
      if (on && $countones(d) > READ_INVERT_ABOVE) return {1'b1, ~d};
      return {1'b0, d};
   endfunction : exp_rd

   // Watchdog sized well above the full run of some five thousand three hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end

   // Main sequence: reset values, then every command under every mode setting.
   initial begin
      logic [31:0] rd;
      logic [2:0] mode;
      logic [8:0] e0, e1;
      logic [17:0] got;
      int k;
      seed = 32'hCE811179;
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} = '0;
      rd_idx = 0;
      foreach (rd_mem[b]) rd_mem[b] = 16'h0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 16; a += 4) begin
         wb_cycle(1'b0, 8'(a), 32'h00000000, rd);
         check(rd, 32'h00000000, "reset value");
      end
      for (int m = 0; m < 8; m++) begin
         mode = 3'(m);
         wb_cycle(1'b1, OFS_MODE_REG_THREE, {24'h000000, mode[1:0], 6'h00}, rd);
         wb_cycle(1'b1, OFS_MODE_REG_THIRTEEN, {26'h0000000, mode[2], 5'h00}, rd);
         wb_cycle(1'b0, OFS_MODE_REG_THREE, 32'h00000000, rd);
         check(rd & 32'h000000C0, {24'h000000, mode[1:0], 6'h00}, "mode three");
         wb_cycle(1'b0, OFS_MODE_REG_THIRTEEN, 32'h00000000, rd);
         check(rd & 32'h00000020, {26'h0000000, mode[2], 5'h00}, "mode thirteen");
         for (int c = 0; c < 8; c++) begin
            // Plain writes carry a low pin while masking is on and write inversion off.
            for (int b = 0; b < BURST_BEATS; b++) begin
               host.tx_dq[b] = 16'($random(seed));
               host.tx_pin[b] = ((c == 0 || c == 2) && mode[2:1] == 2'b00) ? 2'b00 :
                  2'($random(seed));
               rd_mem[b] = 16'($random(seed));
            end
            if (c == 1) begin
               host.tx_dq[0] = 16'hFFFC;
               host.tx_pin[0] = 2'b10;
               host.tx_dq[1][7:0] = 8'hF0;
               host.tx_pin[1][0] = 1'b0;
            end
            rd_mem[0] = 16'h1F0F;
            wr_q.delete();
            rd_idx = 0;
            host.run_burst(3'(c));
            check(32'({dq_oe, pin_oe}), 32'h00000000, "idle enables");
            if (c == 1 && mode[2]) begin
               check(32'(wr_q.size()), 32'h00000000, "illegal stored");
               wb_cycle(1'b0, OFS_STATUS, 32'h00000000, rd);
               check(rd & 32'h00000001, 32'h00000001, "illegal flag");
               wb_cycle(1'b1, OFS_STATUS, 32'h00000001, rd);
               wb_cycle(1'b0, OFS_STATUS, 32'h00000000, rd);
               check(rd & 32'h00000001, 32'h00000000, "flag clear");
            end else if (c < 3) begin
               k = 0;
               for (int b = 0; b < BURST_BEATS; b++) begin
                  e0 = exp_wr(3'(c), host.tx_dq[b][7:0], host.tx_pin[b][0], mode);
                  e1 = exp_wr(3'(c), host.tx_dq[b][15:8], host.tx_pin[b][1], mode);
                  if (e0[8] | e1[8]) begin
                     while (k < wr_q.size() && wr_q[k][17:16] == 2'b00) k++;
                     got = (k < wr_q.size()) ? wr_q[k] : 18'h00000;
                     k++;
                     check(32'(got[17:16]), 32'({e1[8], e0[8]}), "lanes");
                     if (e0[8]) check(32'(got[7:0]), 32'(e0[7:0]), "lane0");
                     if (e1[8]) check(32'(got[15:8]), 32'(e1[7:0]), "lane1");
                  end
               end
               while (k < wr_q.size() && wr_q[k][17:16] == 2'b00) k++;
               check(32'(wr_q.size()), 32'(k), "stores");
            end else if (c < 5) begin
               for (int b = 0; b < BURST_BEATS; b++) begin
                  e0 = exp_rd(rd_mem[b][7:0], mode[0]);
                  e1 = exp_rd(rd_mem[b][15:8], mode[0]);
                  check(32'(host.rx_dq[b]), 32'({e1[7:0], e0[7:0]}), "read");
                  check(32'(host.rx_oe[b]), 32'({1'b1, mode[0], mode[0]}), "oe");
                  if (mode[0]) check(32'(host.rx_pin[b]), 32'({e1[8], e0[8]}), "pin");
               end
            end else if (c == 5) begin
               foreach (train_dq[b]) begin
                  train_dq[b] = host.tx_dq[b];
                  train_pin[b] = host.tx_pin[b];
               end
            end else begin
               for (int b = 0; b < BURST_BEATS; b++) begin
                  check(32'(host.rx_dq[b]), 32'(train_dq[b]), "train data");
                  check(32'(host.rx_oe[b]), (mode == 3'b100) ? 32'h4 : 32'h7, "t oe");
                  if (mode != 3'b100) check(32'(host.rx_pin[b]), 32'(train_pin[b]), "t pin");
               end
            end
         end
      end
      end_sim();
   end
endmodule : dram_byte_mask_inversion_tb_top
